// ===== pkg/sdd_pkg.sv
// Constants for the six-channel sigma-delta decimator and output coder.
// Assumes one master clock; all rates below are derived from it by counters.
package sdd_pkg;
    // Geometry
    localparam int CH_COUNT = 6;
    localparam int ADDR_W = 3;
    localparam int REG_W = 8;
    localparam int WORD_W = 16;
    localparam int ACC_W = 25;
    localparam int FIFO_DEPTH = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] CTRL_A_OFS = 3'h0;
    localparam logic [ADDR_W-1:0] CTRL_B_OFS = 3'h1;
    localparam logic [ADDR_W-1:0] CTRL_C_OFS = 3'h2;
    localparam logic [ADDR_W-1:0] GAIN_D_OFS = 3'h3;
    localparam logic [ADDR_W-1:0] GAIN_E_OFS = 3'h4;
    localparam logic [ADDR_W-1:0] GAIN_F_OFS = 3'h5;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 3'h6;
    localparam logic [ADDR_W-1:0] SPARE_OFS = 3'h7;
    localparam int STORED_REGS = 6;

    // Reset values
    localparam logic [REG_W-1:0] CTRL_RST = 8'h00;

    // Field positions
    localparam int DATA_MODE_BIT = 0;
    localparam int MIXED_MODE_BIT = 1;
    localparam int RATE_LSB = 0;
    localparam int MCLK_DIV_LSB = 4;
    localparam int GAIN_LO_LSB = 0;
    localparam int GAIN_HI_LSB = 4;
    localparam int OVERRUN_BIT = 0;
    localparam int FIFO_LVL_LSB = 4;

    // Rates and coding
    localparam logic [2:0] MOD_DIV_M1 = 3'h7;
    localparam logic [2:0] MCLK_DIV_MAX = 3'h4;
    localparam logic [8:0] BASE_RATIO = 9'h020;
    localparam logic [WORD_W-1:0] POS_FULL_WORD = 16'h7fff;
    localparam int GROUP_DELAY_NS = 25000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int GROUP_DELAY_CYC = GROUP_DELAY_NS / CLK_PERIOD_NS;

    // Gain in dB for each 3-bit select code
    function automatic logic [5:0] gain_db_of(input logic [2:0] code);
        case (code)
            3'h0: gain_db_of = 6'h00;
            3'h1: gain_db_of = 6'h06;
            3'h2: gain_db_of = 6'h0c;
            3'h3: gain_db_of = 6'h12;
            3'h4: gain_db_of = 6'h14;
            3'h5: gain_db_of = 6'h1a;
            3'h6: gain_db_of = 6'h20;
            default: gain_db_of = 6'h26;
        endcase
    endfunction
endpackage

// ===== rtl/sdd_decimator.sv
// Six-channel sinc-cubed decimator with output word coding and a sample FIFO.
// Assumes modulator bit streams arrive asynchronously; downstream drains the FIFO.
//
// Summary of operation
// R1: Each channel consumes one modulator bit every eight divided master clocks.
// R2: Sinc-cubed filter decimates to one word per 256 divided clocks at base ratio.
// R3: Transfer function is three cascaded moving sums of ratio samples, 32 at base ratio.
// R4: Accumulator grows log2(ratio) bits per stage, 24 bits at ratio 256.
// R5: At the highest rate the word carries one zero low bit.
// R6: At lower rates the wider decimator result is truncated into the word.
// R7: Truncation keeps the top bits so full scale matches at every rate.
// R8: Words are two's complement.
// R9: Data mode shifts the 15-bit result left and clears bit 0.
// R10: At or above positive full scale the word saturates to 0x7fff, 0x3fff in mixed mode.
// R11: Mixed mode keeps 15 bits and uses the top bit as control/data flag.
// R12: Mixed mode is on when control A bits 0 and 1 are both one.
// R13: Gain codes 0 to 7 decode to 0,6,12,18,20,26,32,38 dB.
// R14: Divided master clock comes from the master clock through a divider.
// R15: Path latency stays short, group delay about 25 us.
// R16: Six channels each with own input and filter, all updating together.
// R17: Control bits are numbered 0 to 7, bit 7 most significant.
// R18: Sample rate is the output update rate, from divided clock and rate setting.
// R19: Decimation ratio is 32, 64, 128 or 256 per the rate setting.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps

module sdd_fifo #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk, // System clock
    input wire logic reset, // Synchronous, active high
    input wire logic in_valid, // Push request
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word to store
    output logic out_valid, // Word available
    input wire logic out_ready, // Sink takes the word
    output logic [WIDTH-1:0] out_data, // Oldest word
    output logic [$clog2(DEPTH):0] level // Words held
);
    // Pointer width; the count has one bit more to tell full from empty
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
    } fifo_state_type;

    fifo_state_type s_q;
    fifo_state_type s_d;
    logic push;
    logic pop;

    // Handshake and read port
    assign in_ready = (s_q.count != (PW+1)'(DEPTH));
    assign out_valid = (s_q.count != '0);
    assign out_data = s_q.mem[s_q.rd_ptr];
    assign level = s_q.count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and storage update
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr_ptr] = in_data;
            s_d.wr_ptr = s_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_d.rd_ptr = s_q.rd_ptr + 1'b1;
        end
        s_d.count = s_q.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // sdd_fifo

module sdd_decimator
    import sdd_pkg::*;
#(
    parameter int FIFO_WORDS = sdd_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk, // Master clock, 100 MHz
    input wire logic reset, // Synchronous, active high
    input wire logic [sdd_pkg::CH_COUNT-1:0] mod_bit, // Modulator streams, async
    input wire logic [sdd_pkg::ADDR_W-1:0] reg_addr, // Register address
    input wire logic [sdd_pkg::REG_W-1:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [sdd_pkg::REG_W-1:0] reg_rdata, // Read data, cycle after strobe
    output logic sample_valid, // FIFO holds a sample set
    input wire logic sample_ready, // Serial side takes it
    output logic [sdd_pkg::CH_COUNT*sdd_pkg::WORD_W-1:0] sample_data, // Ch0 in low bits
    output logic [sdd_pkg::CH_COUNT-1:0][5:0] gain_db // Decoded gain per channel
);
    import sdd_pkg::*;

    // Level field width follows the FIFO depth
    localparam int LVL_W = $clog2(FIFO_WORDS) + 1;

    // All decimator state, registered as one struct
    typedef struct packed {
        logic [2:0] div_cnt;
        logic [2:0] mod_cnt;
        logic [7:0] dec_cnt;
        logic [CH_COUNT-1:0] sync1;
        logic [CH_COUNT-1:0] sync2;
        logic [CH_COUNT-1:0][ACC_W-1:0] int1;
        logic [CH_COUNT-1:0][ACC_W-1:0] int2;
        logic [CH_COUNT-1:0][ACC_W-1:0] int3;
        logic [CH_COUNT-1:0][ACC_W-1:0] dly1;
        logic [CH_COUNT-1:0][ACC_W-1:0] dly2;
        logic [CH_COUNT-1:0][ACC_W-1:0] dly3;
        logic [STORED_REGS-1:0][REG_W-1:0] regs;
        logic [REG_W-1:0] rdata;
        logic overrun;
        logic word_valid;
        logic word_mixed;
        logic [CH_COUNT-1:0][WORD_W-1:0] words;
    } state_type;

    state_type s_q;
    state_type s_d;
    logic [2:0] div_sel;
    logic [1:0] rate_sel;
    logic [7:0] ratio_m1;
    logic mixed_mode;
    logic dm_tick;
    logic mod_tick;
    logic dec_tick;
    logic fifo_in_ready;
    logic [LVL_W-1:0] fifo_level;

    // Turns a raw sinc-cubed sum into the coded output word
    // Centres the sum on zero, then scales so full scale sits at bit 24
    function automatic logic [WORD_W-1:0] code_word(input logic [ACC_W-1:0] raw,
                                                     input logic [1:0] rate,
                                                     input logic mixed);
        logic signed [ACC_W:0] centred;
        logic signed [ACC_W+10:0] big;
        logic [4:0] half_pos;
        logic [3:0] shift;
        logic [WORD_W-1:0] w;
        half_pos = 5'(14 + 3 * int'(rate));
        shift = 4'(10 - 3 * int'(rate));
        centred = signed'({1'b0, raw}) - signed'((ACC_W+1)'(1) << half_pos); // [R8]
        big = (ACC_W+11)'(centred) <<< shift; // [R7] [R6] full scale at bit 24
        // Saturate before the top code can wrap to negative
        if (big >= signed'((ACC_W+11)'(1) << 24)) begin
            w = POS_FULL_WORD; // [R10]
        end else begin
            w = {big[24:10], 1'b0}; // [R9] [R5]
        end
        if (mixed) begin
            w = {1'b0, w[WORD_W-1:1]}; // [R11] flag low marks sample data
        end
        return w;
    endfunction

    // Control decode; bit 7 is the top of each register
    assign div_sel = (s_q.regs[CTRL_B_OFS][MCLK_DIV_LSB +: 3] > MCLK_DIV_MAX) ?
                     MCLK_DIV_MAX : s_q.regs[CTRL_B_OFS][MCLK_DIV_LSB +: 3]; // [R17]
    assign rate_sel = 2'h3 - s_q.regs[CTRL_B_OFS][RATE_LSB +: 2]; // [R18]
    assign ratio_m1 = 8'((BASE_RATIO << rate_sel) - 9'h001); // [R19] [R4]
    assign mixed_mode = s_q.regs[CTRL_A_OFS][DATA_MODE_BIT] &&
                        s_q.regs[CTRL_A_OFS][MIXED_MODE_BIT]; // [R12]

    // Rate ticks: divided clock, modulator rate, decimated rate
    assign dm_tick = (s_q.div_cnt == div_sel); // [R14]
    assign mod_tick = dm_tick && (s_q.mod_cnt == MOD_DIV_M1); // [R1]
    assign dec_tick = mod_tick && (s_q.dec_cnt == ratio_m1); // [R2]

    // Gain decode for each channel, two per gain register
    always_comb begin
        for (int c = 0; c < CH_COUNT; c++) begin
            gain_db[c] = gain_db_of(s_q.regs[GAIN_D_OFS + c / 2]
                                    [(c % 2 == 0) ? GAIN_LO_LSB : GAIN_HI_LSB +: 3]); // [R13]
        end
    end

    // Next-state logic
    always_comb begin
        logic [CH_COUNT-1:0][ACC_W-1:0] c1;
        logic [CH_COUNT-1:0][ACC_W-1:0] c2;
        logic [CH_COUNT-1:0][ACC_W-1:0] c3;
        c1 = '0;
        c2 = '0;
        c3 = '0;
        s_d = s_q;
        s_d.sync1 = mod_bit;
        s_d.sync2 = s_q.sync1;
        s_d.word_valid = 1'b0;
        s_d.rdata = '0;
        s_d.div_cnt = dm_tick ? 3'h0 : s_q.div_cnt + 3'h1;
        if (dm_tick) begin
            s_d.mod_cnt = s_q.mod_cnt + 3'h1;
        end
        if (mod_tick) begin
            s_d.dec_cnt = dec_tick ? 8'h00 : s_q.dec_cnt + 8'h01;
            for (int c = 0; c < CH_COUNT; c++) begin
                // Three integrators at the modulator rate [R3] [R16]
                s_d.int1[c] = s_q.int1[c] + ACC_W'(s_q.sync2[c]);
                s_d.int2[c] = s_q.int2[c] + s_q.int1[c];
                s_d.int3[c] = s_q.int3[c] + s_q.int2[c];
            end
        end
        if (dec_tick) begin
            for (int c = 0; c < CH_COUNT; c++) begin
                // Three combs at the output rate, one cycle to the word [R3] [R15]
                c1[c] = s_q.int3[c] - s_q.dly1[c];
                c2[c] = c1[c] - s_q.dly2[c];
                c3[c] = c2[c] - s_q.dly3[c];
                s_d.dly1[c] = s_q.int3[c];
                s_d.dly2[c] = c1[c];
                s_d.dly3[c] = c2[c];
                s_d.words[c] = code_word(c3[c], rate_sel, mixed_mode);
            end
            s_d.word_valid = 1'b1; // [R16]
            s_d.word_mixed = mixed_mode;
        end
        // Lost sample set when the FIFO is full; set beats clear
        if (reg_wr && reg_addr == STATUS_OFS && reg_wdata[OVERRUN_BIT]) begin
            s_d.overrun = 1'b0;
        end
        if (s_q.word_valid && !fifo_in_ready) begin
            s_d.overrun = 1'b1;
        end
        // Register writes
        if (reg_wr && reg_addr < ADDR_W'(STORED_REGS)) begin
            s_d.regs[reg_addr] = reg_wdata;
        end
        // Register reads, data only in the following cycle
        if (reg_rd) begin
            if (reg_addr < ADDR_W'(STORED_REGS)) begin
                s_d.rdata = s_q.regs[reg_addr];
            end else if (reg_addr == STATUS_OFS) begin
                s_d.rdata[OVERRUN_BIT] = s_q.overrun;
                s_d.rdata[FIFO_LVL_LSB +: LVL_W] = fifo_level;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
            for (int r = 0; r < STORED_REGS; r++) begin
                s_q.regs[r] <= CTRL_RST;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // Read data comes straight from its flip-flop
    assign reg_rdata = s_q.rdata;

    // Sample sets queue toward the serial side
    sdd_fifo #(
        .WIDTH(CH_COUNT * WORD_W),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(s_q.word_valid),
        .in_ready(fifo_in_ready),
        .in_data(s_q.words),
        .out_valid(sample_valid),
        .out_ready(sample_ready),
        .out_data(sample_data),
        .level(fifo_level)
    );

    // Checks on the design's own behaviour
    a_mod_spacing: assert property (@(posedge ref_clk) disable iff (reset) // [R1]
        mod_tick |=> !mod_tick [*7])
        else $error("modulator tick closer than eight divided clocks");
    a_div_spacing: assert property (@(posedge ref_clk) disable iff (reset) // [R14]
        dm_tick && div_sel == 3'h4 && !reg_wr |=> !dm_tick [*4])
        else $error("divide by five tick too early");
    a_word_follows: assert property (@(posedge ref_clk) disable iff (reset) // [R2]
        dec_tick |=> s_q.word_valid ##1 !s_q.word_valid)
        else $error("word not produced one cycle after decimation");
    a_data_lsb: assert property (@(posedge ref_clk) disable iff (reset) // [R9]
        s_q.word_valid && !s_q.word_mixed |->
        (s_q.words[0][0] == 1'b0) || (s_q.words[0] == POS_FULL_WORD))
        else $error("data word low bit set without saturation");
    a_sat_code: assert property (@(posedge ref_clk) disable iff (reset) // [R10]
        s_q.word_valid && s_q.words[1][0] && !s_q.word_mixed |->
        s_q.words[1] == POS_FULL_WORD)
        else $error("odd data word other than saturation");
    a_mixed_flag: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
        s_q.word_valid && s_q.word_mixed |-> !s_q.words[2][WORD_W-1])
        else $error("mixed mode sample with control flag set");
    a_mixed_enter: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
        reg_wr && reg_addr == CTRL_A_OFS && reg_wdata[1:0] == 2'h3 |=> mixed_mode)
        else $error("mixed mode not entered");
    a_gain_map: assert property (@(posedge ref_clk) disable iff (reset) // [R13]
        reg_wr && reg_addr == GAIN_F_OFS && reg_wdata[2:0] == 3'h4 |=> gain_db[4] == 6'h14)
        else $error("gain code four not 20 dB");
    a_fifo_entry: assert property (@(posedge ref_clk) disable iff (reset) // [R15]
        s_q.word_valid && fifo_in_ready |=> sample_valid)
        else $error("sample set not queued");
    a_overrun_flag: assert property (@(posedge ref_clk) disable iff (reset) // [R16]
        s_q.word_valid && !fifo_in_ready |=> s_q.overrun)
        else $error("lost sample set not flagged");
    a_dec_ratio: assert property (@(posedge ref_clk) disable iff (reset) // [R19]
        dec_tick |-> (s_q.regs[CTRL_B_OFS][RATE_LSB +: 2] == 2'h3 && s_q.dec_cnt == 8'h1f) ||
                     (s_q.regs[CTRL_B_OFS][RATE_LSB +: 2] == 2'h2 && s_q.dec_cnt == 8'h3f) ||
                     (s_q.regs[CTRL_B_OFS][RATE_LSB +: 2] == 2'h1 && s_q.dec_cnt == 8'h7f) ||
                     (s_q.regs[CTRL_B_OFS][RATE_LSB +: 2] == 2'h0 && s_q.dec_cnt == 8'hff))
        else $error("decimation boundary at wrong count");

    // Synchroniser depth, read port, status and stream hold
    a_sync_depth: assert property (@(posedge ref_clk) disable iff (reset) // [R1]
        s_q.sync2 == $past(mod_bit, 2))
        else $error("modulator bit not two flops deep");
    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (reset) // [R17]
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside its cycle");
    a_spare_read: assert property (@(posedge ref_clk) disable iff (reset) // [R17]
        reg_rd && reg_addr == SPARE_OFS |=> reg_rdata == '0)
        else $error("unmapped place read nonzero");
    a_status_read: assert property (@(posedge ref_clk) disable iff (reset) // [R16]
        reg_rd && reg_addr == STATUS_OFS |=> reg_rdata[OVERRUN_BIT] == $past(s_q.overrun))
        else $error("status read misses overrun flag");
    a_overrun_hold: assert property (@(posedge ref_clk) disable iff (reset) // [R16]
        s_q.overrun && !(reg_wr && reg_addr == STATUS_OFS) |=> s_q.overrun)
        else $error("overrun flag lost without clear");
    a_stream_hold: assert property (@(posedge ref_clk) disable iff (reset) // [R18]
        sample_valid && !sample_ready |=> sample_valid && $stable(sample_data))
        else $error("offered sample set changed before taken");
    a_fifo_limit: assert property (@(posedge ref_clk) disable iff (reset) // [R16]
        fifo_level <= LVL_W'(FIFO_WORDS))
        else $error("sample queue level beyond its depth");
    // Decode of gain, mode and divider fields
    a_gain_top: assert property (@(posedge ref_clk) disable iff (reset) // [R13]
        reg_wr && reg_addr == GAIN_F_OFS && reg_wdata[GAIN_HI_LSB +: 3] == 3'h7 |=>
        gain_db[5] == 6'h26)
        else $error("gain code seven not 38 dB");
    a_mixed_leave: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
        reg_wr && reg_addr == CTRL_A_OFS && reg_wdata[1:0] != 2'h3 |=> !mixed_mode)
        else $error("mixed mode kept after mode bits cleared");
    a_div_clamp: assert property (@(posedge ref_clk) disable iff (reset) // [R14]
        s_q.regs[CTRL_B_OFS][MCLK_DIV_LSB +: 3] > MCLK_DIV_MAX |-> div_sel == MCLK_DIV_MAX)
        else $error("divider code beyond divide by five not clamped");
    // Filter pacing
    a_int_idle: assert property (@(posedge ref_clk) disable iff (reset) // [R3]
        !mod_tick |=> $stable(s_q.int3))
        else $error("integrator moved between modulator ticks");
    a_dec_quiet: assert property (@(posedge ref_clk) disable iff (reset) // [R18]
        dec_tick |=> !dec_tick [*8])
        else $error("output update closer than eight cycles");

    // Scenarios worth seeing reached
    c_div_clamp: cover property (@(posedge ref_clk) disable iff (reset)
        dm_tick && div_sel == MCLK_DIV_MAX);
    c_mixed_word: cover property (@(posedge ref_clk) disable iff (reset)
        s_q.word_valid && s_q.word_mixed);
    c_saturated: cover property (@(posedge ref_clk) disable iff (reset)
        s_q.word_valid && s_q.words[0] == POS_FULL_WORD);
    c_overrun: cover property (@(posedge ref_clk) disable iff (reset)
        s_q.word_valid && !fifo_in_ready);
    c_slow_rate: cover property (@(posedge ref_clk) disable iff (reset)
        dec_tick && rate_sel == 2'h3);
endmodule // sdd_decimator

// ===== tb/sdd_sink_model.sv
// Model of the serial side: takes offered sample sets and records the last one.
// Assumes the decimator's valid/ready stream on one rising-edge clock.
`timescale 1ns/1ps
module sdd_sink_model
    import sdd_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire logic reset, // Synchronous, active high
    input wire logic stall, // Bench command to hold off
    input wire logic sample_valid, // Set on offer
    output logic sample_ready, // Willing to take
    input wire logic [sdd_pkg::CH_COUNT*sdd_pkg::WORD_W-1:0] sample_data, // Offered set
    output logic [31:0] pops, // Sets taken
    output logic [sdd_pkg::CH_COUNT*sdd_pkg::WORD_W-1:0] last_data, // Last set taken
    output logic [31:0] last_stamp // Cycle of last take
);
    import sdd_pkg::*;
    logic [31:0] cyc_q;
    // Ready follows the stall command a cycle late, as a slow port would
    always_ff @(posedge ref_clk) begin
        cyc_q <= cyc_q + 32'h1;
        if (reset) begin
            cyc_q <= 32'h0;
            sample_ready <= 1'b0;
            pops <= 32'h0;
            last_data <= '0;
            last_stamp <= 32'h0;
        end else begin
            sample_ready <= !stall;
            if (sample_valid && sample_ready) begin
                pops <= pops + 32'h1;
                last_data <= sample_data;
                last_stamp <= cyc_q;
            end
        end
    end
endmodule // sdd_sink_model

// ===== tb/tb_sigma_delta_decimator_output_coding.sv
// Self-checking bench for the six-channel decimator: registers, gains, coding, rates, FIFO.
// Assumes sdd_pkg and the design files are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module tb_sigma_delta_decimator_output_coding;
    import sdd_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [CH_COUNT-1:0] mod_bit = '0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [REG_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [REG_W-1:0] reg_rdata;
    logic sample_valid;
    logic sample_ready;
    logic [CH_COUNT*WORD_W-1:0] sample_data;
    logic [CH_COUNT-1:0][5:0] gain_db;
    logic stall = 1'b1;
    logic [31:0] pops;
    logic [CH_COUNT*WORD_W-1:0] last_data;
    logic [31:0] last_stamp;
    logic [1:0] mod_src = 2'h0;
    logic [3:0] tgl_q = 4'h0;
    logic [7:0] d;
    int fail_count = 0;
    int comparisons = 0;
    int db_tab[8] = '{0, 6, 12, 18, 20, 26, 32, 38};

    sdd_decimator DUT (.ref_clk(ref_clk), .reset(reset), .mod_bit(mod_bit),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .gain_db(gain_db));
    sdd_sink_model sink (.ref_clk(ref_clk), .reset(reset), .stall(stall),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
        .pops(pops), .last_data(last_data), .last_stamp(last_stamp));

    // Clock, 10 ns period
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // Modulator streams: all low, all high, or a 16-cycle square wave
    always @(posedge ref_clk) begin
        tgl_q <= tgl_q + 4'h1;
        mod_bit <= (mod_src == 2'h2) ? {CH_COUNT{tgl_q[3]}} : {CH_COUNT{mod_src[0]}};
    end

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        v = reg_rdata;
    endtask

    // Bounded wait for n more sets taken by the sink
    task automatic wait_sets(input int n);
        int target;
        target = pops + n;
        for (int i = 0; i < 12000 * n && pops < target; i++) @(posedge ref_clk);
        if (pops < target) begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    // Bounded poll of the FIFO level field
    task automatic poll_level(input logic [3:0] lvl);
        for (int i = 0; i < 400; i++) begin
            rd(STATUS_OFS, d);
            if (d[7:4] == lvl) break;
        end
        if (d[7:4] != lvl) begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    // Configure, skip start-up sets, then check word and set spacing
    task automatic run_phase(input logic [7:0] ca, input logic [1:0] rate,
        input logic [2:0] div, input logic [1:0] src, input logic [15:0] w,
        input logic [31:0] per);
        logic [31:0] t0;
        mod_src <= src;
        wr(CTRL_A_OFS, ca);
        wr(CTRL_B_OFS, {1'b0, div, 2'b00, rate});
        wait_sets(5);
        t0 = last_stamp;
        wait_sets(1);
        `CHK(last_data, {CH_COUNT{w}})
        if (per != 32'h0) `CHK(last_stamp - t0, per)
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        // Reset values, unmapped place ignores writes
        wr(SPARE_OFS, 8'h5a);
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d);
            `CHK(d, 8'h00)
        end
        wr(CTRL_C_OFS, 8'h81);
        rd(CTRL_C_OFS, d);
        `CHK(d, 8'h81)
        // Every gain code across the channels, two codes on each channel
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 3; k++) begin
                wr(3'(GAIN_D_OFS + k), {1'b0, 3'(2 * k + 2 * p + 1), 1'b0, 3'(2 * k + 2 * p)});
            end
            @(posedge ref_clk);
            for (int c = 0; c < CH_COUNT; c++) begin
                `CHK(gain_db[c], 6'(db_tab[(c + 2 * p) % 8]))
            end
        end
        stall <= 1'b0;
        // Full scale at every ratio, then divider, sign and modes
        run_phase(8'h01, 2'h3, 3'h0, 2'h1, 16'h7fff, 32'd256);
        run_phase(8'h01, 2'h2, 3'h0, 2'h1, 16'h7fff, 32'd512);
        run_phase(8'h01, 2'h1, 3'h0, 2'h1, 16'h7fff, 32'd1024);
        run_phase(8'h01, 2'h0, 3'h0, 2'h1, 16'h7fff, 32'd2048);
        run_phase(8'h01, 2'h3, 3'h1, 2'h1, 16'h7fff, 32'd512);
        run_phase(8'h01, 2'h3, 3'h7, 2'h1, 16'h7fff, 32'd1280);
        run_phase(8'h01, 2'h3, 3'h0, 2'h0, 16'h8000, 32'd256);
        run_phase(8'h01, 2'h3, 3'h0, 2'h2, 16'h0000, 32'd0);
        run_phase(8'h03, 2'h3, 3'h0, 2'h0, 16'h4000, 32'd0);
        run_phase(8'h03, 2'h3, 3'h0, 2'h1, 16'h3fff, 32'd0);
        run_phase(8'h02, 2'h3, 3'h0, 2'h1, 16'h7fff, 32'd0);
        // Fill the FIFO with the sink stalled, drop a set, clear, drain
        stall <= 1'b1;
        poll_level(4'h4);
        repeat (300) @(posedge ref_clk);
        rd(STATUS_OFS, d);
        `CHK(d, 8'h41)
        wr(STATUS_OFS, 8'h01);
        rd(STATUS_OFS, d);
        `CHK(d, 8'h40)
        stall <= 1'b0;
        poll_level(4'h0);
        `CHK(d, 8'h00)
        tally_and_finish();
    end
endmodule // tb_sigma_delta_decimator_output_coding
